// file: hdl/bbcc_top.sv
// battery backed calendar clock with alarm, tick and register port
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module bbcc_top #(
    parameter int unsigned TICK_W = 32
) (
    // clock and reset
    input  wire logic                        clk_sys_i,
    input  wire logic                        reset_i,
    // register port
    input  bbcc_pkg::bbcc_addr_t             addr_i,
    input  wire logic [bbcc_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                        wr_i,
    input  wire logic                        rd_i,
    output logic [bbcc_pkg::DATA_W-1:0]      rdata_o,
    // crystal and supply pins
    input  wire logic                        osc_input_i,
    output logic                             osc_output_o,
    input  wire logic                        backup_supply_pin_i,
    input  wire logic                        main_power_off_i,
    // events
    output logic                             irq_o,
    output logic                             wake_o
);
    localparam int N_SYNC = 3;
    localparam int S_OSC  = 0;
    localparam int S_OFF  = 1;
    localparam int S_BAK  = 2;

    logic [N_SYNC-1:0]                pin_async;
    logic [N_SYNC-1:0]                sync1_reg;
    logic [N_SYNC-1:0]                sync2_reg;
    logic                             osc_prev_reg;
    logic                             osc_out_reg;
    logic                             osc_run;
    logic                             bus_ok;
    logic                             wr_ok;
    logic                             rd_ok;
    logic [bbcc_pkg::PRE_W-1:0]       pre_reg;
    logic                             sec_tick;
    logic                             sec_d_reg;
    logic [bbcc_pkg::CTRL_W-1:0]      ctrl_reg;
    logic [bbcc_pkg::EV_W-1:0]        mask_reg;
    logic [bbcc_pkg::EV_W-1:0]        pend_reg;
    logic [bbcc_pkg::EV_W-1:0]        pend_next;
    logic [bbcc_pkg::EV_W-1:0]        ev_set;
    logic [bbcc_pkg::EV_W-1:0]        ev_clr;
    logic [bbcc_pkg::ALMC_W-1:0]      almc_reg;
    bbcc_pkg::bbcc_bcd_t              alm_reg [bbcc_pkg::N_ALM];
    logic [bbcc_pkg::N_ALM-1:0]       alm_eq;
    logic                             alarm_hit;
    logic [TICK_W-1:0]                period_reg;
    logic [TICK_W-1:0]                tick_cnt_reg;
    logic                             tick_event;
    logic [bbcc_pkg::N_FLD-1:0]       wr_fld;
    bbcc_pkg::bbcc_time_t             time_now;
    logic [bbcc_pkg::DATA_W-1:0]      rd_mux;
    logic [bbcc_pkg::DATA_W-1:0]      rdata_reg;

    // pin synchronisers; stage one feeds stage two only
    assign pin_async = {backup_supply_pin_i, main_power_off_i, osc_input_i};
    for (genvar gs = 0; gs < N_SYNC; gs++)
    begin : g_sync
        always_ff @(posedge clk_sys_i)
        begin
            if (reset_i)
            begin
                sync1_reg[gs] <= 1'b0;
                sync2_reg[gs] <= 1'b0;
            end
            else
            begin
                sync1_reg[gs] <= pin_async[gs];
                sync2_reg[gs] <= sync1_reg[gs];
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            osc_prev_reg <= 1'b0;
            osc_out_reg  <= 1'b0;
        end
        else
        begin
            osc_prev_reg <= sync2_reg[S_OSC];
            osc_out_reg  <= ~sync2_reg[S_OSC];
        end
    end

    // one count per oscillator rising edge while the backup rail is up
    assign osc_run = sync2_reg[S_OSC] & ~osc_prev_reg & sync2_reg[S_BAK];
    // main power off only blocks the bus; time keeps running
    assign bus_ok  = ~sync2_reg[S_OFF]; // RULE7
    assign wr_ok   = wr_i & bus_ok;
    assign rd_ok   = rd_i & bus_ok;

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            pre_reg <= '0;
        else if (osc_run)
            pre_reg <= (pre_reg == bbcc_pkg::PRE_LAST) ? '0
                       : pre_reg + 1'b1; // RULE6 RULE7
    end

    assign sec_tick = osc_run & (pre_reg == bbcc_pkg::PRE_LAST); // RULE6

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            sec_d_reg <= 1'b0;
        else
            sec_d_reg <= sec_tick;
    end

    always_comb
    begin
        for (int i = 0; i < bbcc_pkg::N_FLD; i++)
            wr_fld[i] = wr_ok & ctrl_reg[bbcc_pkg::C_TWE]
                        & (addr_i == bbcc_pkg::A_TIME[i]);
    end

    bbcc_calendar u_cal (
        .clk_sys_i  (clk_sys_i),
        .reset_i    (reset_i),
        .sec_tick_i (sec_tick),
        .wr_fld_i   (wr_fld),
        .wdata_i    (wdata_i[7:0]),
        .time_o     (time_now)
    );

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            ctrl_reg <= '0;
        else if (wr_ok && addr_i == bbcc_pkg::A_CTRL)
            ctrl_reg <= wdata_i[bbcc_pkg::CTRL_W-1:0];
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            mask_reg <= '0;
        else if (wr_ok && addr_i == bbcc_pkg::A_MASK)
            mask_reg <= wdata_i[bbcc_pkg::EV_W-1:0];
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            period_reg <= '0; // RULE9
        else if (wr_ok && addr_i == bbcc_pkg::A_TICK)
            period_reg <= wdata_i[TICK_W-1:0]; // RULE9
    end

    // a new period takes effect at the next reload, not mid count
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            tick_cnt_reg <= '0;
        else if (!ctrl_reg[bbcc_pkg::C_TICK_EN])
            tick_cnt_reg <= period_reg; // RULE9
        else if (osc_run)
            tick_cnt_reg <= (tick_cnt_reg == '0) ? period_reg
                            : tick_cnt_reg - 1'b1; // RULE4 RULE5
    end

    // period n gives n+1 oscillator cycles, about 30.5 us resolution
    assign tick_event = osc_run & ctrl_reg[bbcc_pkg::C_TICK_EN]
                        & (tick_cnt_reg == '0); // RULE4 RULE5

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            almc_reg <= '0;
        else if (wr_ok && addr_i == bbcc_pkg::A_ALMC)
            almc_reg <= wdata_i[bbcc_pkg::ALMC_W-1:0];
    end

    for (genvar ga = 0; ga < bbcc_pkg::N_ALM; ga++)
    begin : g_alm
        always_ff @(posedge clk_sys_i)
        begin
            if (reset_i)
                alm_reg[ga] <= bbcc_pkg::ALM_RST[ga]; // RULE8
            else if (wr_ok && addr_i == bbcc_pkg::A_ALM[ga])
                alm_reg[ga] <= wdata_i[7:0];
        end
        assign alm_eq[ga] = ~almc_reg[ga] | (alm_reg[ga] ==
            time_now[bbcc_pkg::ALM_FLD[ga]*8 +: 8]); // RULE12
    end

    // compared one cycle after the second step so the new time is seen
    assign alarm_hit = sec_d_reg & almc_reg[bbcc_pkg::ALMC_GLOBAL]
        & (|almc_reg[bbcc_pkg::N_ALM-1:0]) & (&alm_eq); // RULE12 RULE3

    always_comb
    begin
        ev_set = '0;
        ev_set[bbcc_pkg::P_TICK]    = tick_event
                                      & ~ctrl_reg[bbcc_pkg::C_TICK_WAKE];
        ev_set[bbcc_pkg::P_TICK_WK] = tick_event
                                      & ctrl_reg[bbcc_pkg::C_TICK_WAKE];
        ev_set[bbcc_pkg::P_ALM]     = alarm_hit
                                      & ~ctrl_reg[bbcc_pkg::C_ALM_WAKE];
        ev_set[bbcc_pkg::P_ALM_WK]  = alarm_hit
                                      & ctrl_reg[bbcc_pkg::C_ALM_WAKE];
    end

    // read clears all, write of one clears that bit; a new event wins
    always_comb
    begin
        ev_clr = '0;
        if (rd_ok && addr_i == bbcc_pkg::A_PEND)
            ev_clr = '1;
        else if (wr_ok && addr_i == bbcc_pkg::A_PEND)
            ev_clr = wdata_i[bbcc_pkg::EV_W-1:0]; // RULE11
        pend_next = (pend_reg & ~ev_clr) | ev_set; // RULE11
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            pend_reg <= '0;
        else
            pend_reg <= pend_next; // RULE3 RULE4 RULE11
    end

    assign irq_o  = |(pend_reg & mask_reg & bbcc_pkg::EV_IRQ); // RULE3 RULE4
    assign wake_o = |(pend_reg & mask_reg & bbcc_pkg::EV_WAKE); // RULE3 RULE4

    always_comb
    begin
        rd_mux = '0;
        if (addr_i == bbcc_pkg::A_PEND)
            rd_mux = bbcc_pkg::DATA_W'(pend_reg);
        if (addr_i == bbcc_pkg::A_MASK)
            rd_mux = bbcc_pkg::DATA_W'(mask_reg);
        if (addr_i == bbcc_pkg::A_CTRL)
            rd_mux = bbcc_pkg::DATA_W'(ctrl_reg);
        if (addr_i == bbcc_pkg::A_TICK)
            rd_mux = bbcc_pkg::DATA_W'(period_reg);
        if (addr_i == bbcc_pkg::A_ALMC)
            rd_mux = bbcc_pkg::DATA_W'(almc_reg);
        if (addr_i == bbcc_pkg::A_TNOW)
            rd_mux = bbcc_pkg::DATA_W'(tick_cnt_reg); // RULE10
        for (int i = 0; i < bbcc_pkg::N_ALM; i++)
            if (addr_i == bbcc_pkg::A_ALM[i])
                rd_mux = bbcc_pkg::DATA_W'(alm_reg[i]);
        for (int i = 0; i < bbcc_pkg::N_FLD; i++)
            if (addr_i == bbcc_pkg::A_TIME[i])
                rd_mux = bbcc_pkg::DATA_W'(time_now[i*8 +: 8]); // RULE1
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            rdata_reg <= '0;
        else
            rdata_reg <= rd_ok ? rd_mux : '0;
    end

    assign rdata_o      = rdata_reg;
    assign osc_output_o = osc_out_reg;

    // helper: oscillator edges seen since the last second step
    logic [bbcc_pkg::PRE_W-1:0] osc_seen_reg;
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i || sec_tick)
            osc_seen_reg <= '0;
        else if (osc_run)
            osc_seen_reg <= osc_seen_reg + 1'b1;
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    AST_ALARM_ROUTE: assert property ( // RULE3
        alarm_hit |=> ($past(ctrl_reg[bbcc_pkg::C_ALM_WAKE])
            ? pend_reg[bbcc_pkg::P_ALM_WK] : pend_reg[bbcc_pkg::P_ALM]))
        else $error("alarm event not latched on its path");
    AST_TICK_ROUTE: assert property ( // RULE4
        tick_event |=> ($past(ctrl_reg[bbcc_pkg::C_TICK_WAKE])
            ? pend_reg[bbcc_pkg::P_TICK_WK] : pend_reg[bbcc_pkg::P_TICK]))
        else $error("tick event not latched on its path");
    AST_TICK_DOWN: assert property ( // RULE5
        osc_run && ctrl_reg[bbcc_pkg::C_TICK_EN] && tick_cnt_reg != '0
        |=> tick_cnt_reg == $past(tick_cnt_reg) - 1'b1)
        else $error("tick counter did not step down");
    AST_SEC_SPAN: assert property ( // RULE6
        sec_tick |-> osc_seen_reg == bbcc_pkg::PRE_LAST)
        else $error("second step not after 32768 oscillator cycles");
    AST_COUNT_OFF: assert property ( // RULE7
        sync2_reg[S_OFF] && osc_run && pre_reg != bbcc_pkg::PRE_LAST
        |=> pre_reg == $past(pre_reg) + 1'b1)
        else $error("prescaler stalled with main power off");
    AST_ALM_RESET: assert property ( // RULE8
        $past(reset_i) |->
        alm_reg[bbcc_pkg::I_ADATE] == bbcc_pkg::ALM_RST[bbcc_pkg::I_ADATE] &&
        alm_reg[bbcc_pkg::I_AMON] == bbcc_pkg::ALM_RST[bbcc_pkg::I_AMON] &&
        alm_reg[bbcc_pkg::I_ASEC] == bbcc_pkg::ALM_RST[bbcc_pkg::I_ASEC])
        else $error("alarm fields wrong after reset");
    AST_TICK_RELOAD: assert property ( // RULE9
        tick_event |=> tick_cnt_reg == $past(period_reg))
        else $error("tick counter not reloaded from period");
    AST_TNOW_READ: assert property ( // RULE10
        rd_ok && addr_i == bbcc_pkg::A_TNOW
        |=> rdata_o == bbcc_pkg::DATA_W'($past(tick_cnt_reg)))
        else $error("running tick count read wrong");
    AST_PEND_W1C: assert property ( // RULE11
        wr_ok && addr_i == bbcc_pkg::A_PEND && wdata_i[bbcc_pkg::P_TICK]
        && !ev_set[bbcc_pkg::P_TICK] |=> !pend_reg[bbcc_pkg::P_TICK])
        else $error("tick flag not cleared by writing one");
    AST_SET_WINS: assert property ( // RULE11
        ev_set[bbcc_pkg::P_ALM] |=> pend_reg[bbcc_pkg::P_ALM])
        else $error("alarm flag lost against a clear");
    AST_ALARM_MATCH: assert property ( // RULE12
        almc_reg[0] && alm_reg[bbcc_pkg::I_ASEC] != time_now.sec
        |-> !alarm_hit)
        else $error("alarm hit with an enabled field unequal");
    // refusals and holds that the bench reaches on purpose
    AST_TICK_HOLD: assert property ( // RULE9
        !ctrl_reg[bbcc_pkg::C_TICK_EN] |=> tick_cnt_reg == $past(period_reg))
        else $error("tick counter not held at period while disabled");
    AST_BAK_STOP: assert property ( // RULE7
        !sync2_reg[S_BAK] |=> pre_reg == $past(pre_reg))
        else $error("prescaler moved without backup supply");
    AST_BUS_OFF: assert property ( // RULE7
        sync2_reg[S_OFF] && rd_i |=> rdata_o == '0)
        else $error("read answered while main power off");
    AST_PEND_RD_CLR: assert property ( // RULE11
        rd_ok && addr_i == bbcc_pkg::A_PEND && ev_set == '0
        |=> pend_reg == '0)
        else $error("pending flags not cleared by read");
    AST_TIME_LOCK: assert property ( // RULE1
        wr_ok && !ctrl_reg[bbcc_pkg::C_TWE] && !sec_tick &&
        addr_i == bbcc_pkg::A_TIME[bbcc_pkg::F_SEC]
        |=> time_now.sec == $past(time_now.sec))
        else $error("time field written while write enable low");
    COV_ALARM: cover property (alarm_hit);
    COV_TICK_WAKE: cover property (ev_set[bbcc_pkg::P_TICK_WK]);
    COV_IRQ: cover property ($rose(irq_o));
    COV_WAKE: cover property ($rose(wake_o));
endmodule : bbcc_top

// file: hdl/bbcc_pkg.sv
// constants, types and helpers for the battery backed calendar clock
// Behaviour
// RULE1: time and calendar kept as bcd counters, seconds up to year.
// RULE2: leap years add february 29; year 99 rolls to 00 cleanly.
// RULE3: alarm match raises alarm interrupt or wake request.
// RULE4: tick counter expiry raises tick interrupt or wake request.
// RULE5: periodic tick usable as a millisecond operating system tick.
// RULE6: one second counted per 32768 crystal oscillator cycles.
// RULE7: counting continues on backup supply while main power is off.
// RULE8: reset loads alarm date and month with one, other alarm fields zero.
// RULE9: writable tick period register reloads tick counter, resets to zero.
// RULE10: running tick counter readable through a read only register.
// RULE11: alarm and tick pending flags latched, cleared by writing one.
// RULE12: alarm matches only when all enabled alarm fields equal time.
package bbcc_pkg;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned OSC_HZ = 32768;
    localparam int unsigned PRE_W  = $clog2(OSC_HZ);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(OSC_HZ - 1);
    localparam int unsigned N_FLD  = 7;
    localparam int unsigned N_ALM  = 6;
    localparam int F_SEC  = 0;
    localparam int F_MIN  = 1;
    localparam int F_DATE = 3;
    localparam int F_MON  = 5;
    localparam int F_YEAR = 6;
    typedef logic [7:0]  bbcc_bcd_t;
    typedef logic [31:0] bbcc_addr_t;
    typedef struct packed {
        bbcc_bcd_t year;
        bbcc_bcd_t mon;
        bbcc_bcd_t dow;
        bbcc_bcd_t date;
        bbcc_bcd_t hour;
        bbcc_bcd_t min;
        bbcc_bcd_t sec;
    } bbcc_time_t;
    localparam bbcc_time_t TIME_RST = {8'h00, 8'h01, 8'h01, 8'h01,
                                       8'h00, 8'h00, 8'h00};
    localparam bbcc_time_t TIME_MAX = {8'h99, 8'h12, 8'h07, 8'h31,
                                       8'h23, 8'h59, 8'h59};
    localparam bbcc_bcd_t DAY_28  = 8'h28;
    localparam bbcc_bcd_t DAY_29  = 8'h29;
    localparam bbcc_bcd_t DAY_30  = 8'h30;
    localparam bbcc_bcd_t MON_FEB = 8'h02;
    localparam bbcc_bcd_t MON_APR = 8'h04;
    localparam bbcc_bcd_t MON_JUN = 8'h06;
    localparam bbcc_bcd_t MON_SEP = 8'h09;
    localparam bbcc_bcd_t MON_NOV = 8'h11;
    localparam logic [3:0] DIGIT_MAX  = 4'h9;
    localparam logic [3:0] DIGIT_ONE  = 4'h1;
    localparam logic [3:0] DIGIT_ZERO = 4'h0;
    localparam logic [1:0] LEAP_ODD   = 2'h2;
    localparam logic [1:0] LEAP_EVEN  = 2'h0;
    localparam bbcc_addr_t A_PEND = 32'h7e005030;
    localparam bbcc_addr_t A_MASK = 32'h7e005034;
    localparam bbcc_addr_t A_CTRL = 32'h7e005040;
    localparam bbcc_addr_t A_TICK = 32'h7e005044;
    localparam bbcc_addr_t A_ALMC = 32'h7e005050;
    localparam bbcc_addr_t A_TNOW = 32'h7e005090;
    localparam bbcc_addr_t A_TIME [N_FLD] = '{32'h7e005070, 32'h7e005074,
        32'h7e005078, 32'h7e00507c, 32'h7e005080, 32'h7e005084,
        32'h7e005088};
    localparam bbcc_addr_t A_ALM [N_ALM] = '{32'h7e005054, 32'h7e005058,
        32'h7e00505c, 32'h7e005060, 32'h7e005064, 32'h7e005068};
    localparam int ALM_FLD [N_ALM] = '{0, 1, 2, 3, 5, 6};
    localparam bbcc_bcd_t ALM_RST [N_ALM] = '{8'h00, 8'h00, 8'h00,
        8'h01, 8'h01, 8'h00};
    localparam int I_ASEC  = 0;
    localparam int I_ADATE = 3;
    localparam int I_AMON  = 4;
    localparam int CTRL_W      = 4;
    localparam int C_TWE       = 0;
    localparam int C_TICK_EN   = 1;
    localparam int C_TICK_WAKE = 2;
    localparam int C_ALM_WAKE  = 3;
    localparam int ALMC_W      = 7;
    localparam int ALMC_GLOBAL = 6;
    localparam int EV_W      = 4;
    localparam int P_TICK    = 0;
    localparam int P_ALM     = 1;
    localparam int P_TICK_WK = 2;
    localparam int P_ALM_WK  = 3;
    localparam logic [EV_W-1:0] EV_IRQ  = 4'h3;
    localparam logic [EV_W-1:0] EV_WAKE = 4'hc;

    function automatic bbcc_bcd_t bbcc_bcd_inc(input bbcc_bcd_t v);
        if (v[3:0] == DIGIT_MAX)
            return {v[7:4] + DIGIT_ONE, DIGIT_ZERO};
        return {v[7:4], v[3:0] + DIGIT_ONE};
    endfunction : bbcc_bcd_inc
endpackage : bbcc_pkg

// file: hdl/bbcc_calendar.sv
// bcd calendar counters with leap year and century rollover
`timescale 1ns/1ps
module bbcc_calendar (
    // clock and reset
    input  wire logic                     clk_sys_i,
    input  wire logic                     reset_i,
    // second strobe and field writes
    input  wire logic                     sec_tick_i,
    input  wire logic [bbcc_pkg::N_FLD-1:0] wr_fld_i,
    input  bbcc_pkg::bbcc_bcd_t           wdata_i,
    // current time
    output bbcc_pkg::bbcc_time_t          time_o
);
    bbcc_pkg::bbcc_bcd_t         fld_reg [bbcc_pkg::N_FLD];
    bbcc_pkg::bbcc_bcd_t         fmax    [bbcc_pkg::N_FLD];
    logic [bbcc_pkg::N_FLD-1:0]  cin;
    logic [bbcc_pkg::N_FLD-1:0]  at_max;
    bbcc_pkg::bbcc_bcd_t         last_day;
    logic                        leap;
    bbcc_pkg::bbcc_bcd_t         year;
    bbcc_pkg::bbcc_time_t        time_now;

    assign year = fld_reg[bbcc_pkg::F_YEAR];
    // years 00..99 stand for 2000..2099, so 00 is a leap year
    assign leap = (year[1:0] == (year[4] ? bbcc_pkg::LEAP_ODD
                                          : bbcc_pkg::LEAP_EVEN)); // RULE2

    always_comb
    begin
        case (fld_reg[bbcc_pkg::F_MON])
            bbcc_pkg::MON_FEB: last_day = leap ? bbcc_pkg::DAY_29
                                               : bbcc_pkg::DAY_28; // RULE2
            bbcc_pkg::MON_APR,
            bbcc_pkg::MON_JUN,
            bbcc_pkg::MON_SEP,
            bbcc_pkg::MON_NOV: last_day = bbcc_pkg::DAY_30;
            default:           last_day = bbcc_pkg::TIME_MAX.date;
        endcase
    end

    always_comb
    begin
        for (int i = 0; i < bbcc_pkg::N_FLD; i++)
        begin
            fmax[i]   = bbcc_pkg::TIME_MAX[i*8 +: 8];
            time_now[i*8 +: 8] = fld_reg[i];
        end
        fmax[bbcc_pkg::F_DATE] = last_day;
        for (int i = 0; i < bbcc_pkg::N_FLD; i++)
            at_max[i] = (fld_reg[i] >= fmax[i]);
    end

    // carry chain; day of week steps with the date
    always_comb
    begin
        cin[0] = sec_tick_i;
        cin[1] = cin[0] & at_max[0];
        cin[2] = cin[1] & at_max[1];
        cin[3] = cin[2] & at_max[2];
        cin[4] = cin[3];
        cin[5] = cin[3] & at_max[3];
        cin[6] = cin[5] & at_max[5]; // RULE2
    end

    // out of range values written by software roll over on the next carry
    for (genvar gi = 0; gi < bbcc_pkg::N_FLD; gi++)
    begin : g_fld
        always_ff @(posedge clk_sys_i)
        begin
            if (reset_i)
                fld_reg[gi] <= bbcc_pkg::TIME_RST[gi*8 +: 8];
            else if (wr_fld_i[gi])
                fld_reg[gi] <= wdata_i;
            else if (cin[gi])
                fld_reg[gi] <= at_max[gi] ? bbcc_pkg::TIME_RST[gi*8 +: 8]
                             : bbcc_pkg::bbcc_bcd_inc(fld_reg[gi]); // RULE1
        end
    end

    assign time_o = time_now;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    AST_SEC_DIGIT: assert property ( // RULE1
        cin[0] && !at_max[0] && !wr_fld_i[0] &&
        fld_reg[0][3:0] == bbcc_pkg::DIGIT_MAX
        |=> fld_reg[0][3:0] == bbcc_pkg::DIGIT_ZERO &&
            fld_reg[0][7:4] == $past(fld_reg[0][7:4]) + bbcc_pkg::DIGIT_ONE)
        else $error("bcd second digit did not carry");
    AST_MIN_CARRY: assert property ( // RULE1
        cin[1] && !wr_fld_i[0] |=> fld_reg[0] == bbcc_pkg::TIME_RST.sec)
        else $error("seconds did not wrap at minute carry");
    AST_LEAP_DAY: assert property ( // RULE2
        cin[3] && !wr_fld_i[3] && leap &&
        fld_reg[bbcc_pkg::F_MON] == bbcc_pkg::MON_FEB &&
        fld_reg[3] == bbcc_pkg::DAY_28 |=> fld_reg[3] == bbcc_pkg::DAY_29)
        else $error("leap february skipped day 29");
    AST_CENTURY: assert property ( // RULE2
        cin[6] && !wr_fld_i[6] && year == bbcc_pkg::TIME_MAX.year
        |=> year == bbcc_pkg::TIME_RST.year)
        else $error("year did not roll from 99 to 00");
    COV_CENTURY: cover property (cin[6] && at_max[6]);
endmodule : bbcc_calendar

// file: test/bbcc_osc_model.sv
// watch crystal model feeding the oscillator input
`timescale 1ns/1ps
module bbcc_osc_model #(
    parameter real HALF_NS = 15258.789
) (
    // oscillator pins
    output logic      osc_o,
    input  wire logic fb_i
);
    // crystal keeps swinging, no framing to stop it
    initial
    begin
        osc_o = 1'b0;
        forever #(HALF_NS) osc_o = ~osc_o;
    end
endmodule : bbcc_osc_model

// file: test/bbcc_top_tb_top.sv
// self-checking bench for the calendar clock
`timescale 1ns/1ps
module bbcc_top_tb_top;
    logic                 clk = 1'b0;
    logic                 rst = 1'b1;
    bbcc_pkg::bbcc_addr_t addr = '0;
    logic [31:0]          wdat = '0;
    logic                 wr = 1'b0;
    logic                 rd = 1'b0;
    logic                 poff = 1'b0;
    logic                 bak = 1'b1;
    logic [31:0]          rdat;
    logic                 osc;
    logic                 osc_fb;
    logic                 irq;
    logic                 wake;
    logic [31:0]          rv;
    logic [31:0]          seed = 32'hc9ba9e78;
    int                   error_cnt = 0;
    int                   cmp_count = 0;
    int                   n;
    int                   cyc;
    bbcc_pkg::bbcc_bcd_t  bv;
    int lo [7] = '{0, 0, 0, 1, 1, 1, 0};
    int sp [7] = '{60, 60, 24, 28, 7, 12, 100};

    always #12.5 clk = ~clk;

    bbcc_top dut (.clk_sys_i(clk), .reset_i(rst), .addr_i(addr),
        .wdata_i(wdat), .wr_i(wr), .rd_i(rd), .rdata_o(rdat),
        .osc_input_i(osc), .osc_output_o(osc_fb),
        .backup_supply_pin_i(bak), .main_power_off_i(poff),
        .irq_o(irq), .wake_o(wake));
    bbcc_osc_model osc_m (.osc_o(osc), .fb_i(osc_fb));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    function automatic bbcc_pkg::bbcc_bcd_t to_bcd(input int v);
        return 8'((v / 10) * 16 + v % 10);
    endfunction : to_bcd

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task wr_reg(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdat <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg

    // data stand only in the cycle after the strobe
    task rd_reg(input logic [31:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 rv = rdat;
    endtask : rd_reg

    task wait_ev(input int lim, input bit w);
        for (cyc = 0; cyc < lim; cyc++)
        begin
            @(posedge clk);
            if ((w ? wake : irq) === 1'b1)
                break;
        end
        #1;
    endtask : wait_ev

    task finish_test;
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test

    // three tick periods and a 2600 cycle freeze, under 0.6 ms at most; well under the 1.5 ms budget
    initial
    begin
        #1_500_000;
        error_cnt++;
        finish_test();
    end

    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < bbcc_pkg::N_ALM; i++)
        begin
            rd_reg(bbcc_pkg::A_ALM[i]);
            chk(rv, (i == 3 || i == 4) ? 32'h1 : 32'h0);
        end
        rd_reg(bbcc_pkg::A_TICK);
        chk(rv, 32'h0);
        rd_reg(bbcc_pkg::A_TNOW);
        chk(rv, 32'h0);
        rd_reg(bbcc_pkg::A_PEND);
        chk(rv, 32'h0);
        rd_reg(32'h7e0050fc);
        chk(rv, 32'h0);
        // feedback pin is the crystal inverted after the synchroniser
        @(posedge osc);
        repeat (4) @(posedge clk);
        #1 chk({31'h0, osc_fb}, 32'h0);
        @(negedge osc);
        repeat (4) @(posedge clk);
        #1 chk({31'h0, osc_fb}, 32'h1);
        // time write refused while write enable is low
        wr_reg(bbcc_pkg::A_TIME[0], 32'h33);
        rd_reg(bbcc_pkg::A_TIME[0]);
        chk(rv, 32'h0);
        wr_reg(bbcc_pkg::A_CTRL, 32'h1);
        for (int i = 0; i < bbcc_pkg::N_FLD; i++)
        begin
            seed = xs(seed);
            bv = to_bcd(lo[i] + int'(seed % sp[i]));
            wr_reg(bbcc_pkg::A_TIME[i], {24'h0, bv});
            rd_reg(bbcc_pkg::A_TIME[i]);
            chk(rv, {24'h0, bv});
        end
        seed = xs(seed);
        n = 1 + int'(seed % 4);
        wr_reg(bbcc_pkg::A_TICK, n);
        rd_reg(bbcc_pkg::A_TICK);
        chk(rv, n);
        wr_reg(bbcc_pkg::A_MASK, 32'h3);
        wr_reg(bbcc_pkg::A_CTRL, 32'h3);
        rd_reg(bbcc_pkg::A_TNOW);
        chk({31'h0, rv <= n}, 32'h1);
        wait_ev((n + 2) * 1300, 1'b0);
        chk({31'h0, irq}, 32'h1);
        rd_reg(bbcc_pkg::A_PEND);
        chk(rv, 32'h1);
        chk({31'h0, irq}, 32'h0);
        // next event spaced by n+1 crystal periods
        wait_ev((n + 2) * 1300, 1'b0);
        rv = {31'h0, cyc > (n + 1) * 1214 && cyc <= (n + 1) * 1221};
        chk(rv, 32'h1);
        wr_reg(bbcc_pkg::A_PEND, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr_reg(bbcc_pkg::A_MASK, 32'hc);
        wr_reg(bbcc_pkg::A_CTRL, 32'h7);
        @(posedge clk);
        poff <= 1'b1;
        repeat (3) @(posedge clk);
        rd_reg(bbcc_pkg::A_TICK);
        chk(rv, 32'h0);
        wait_ev((n + 2) * 1300, 1'b1);
        chk({30'h0, wake, irq}, 32'h2);
        @(posedge clk);
        poff <= 1'b0;
        repeat (3) @(posedge clk);
        rd_reg(bbcc_pkg::A_PEND);
        chk(rv, 32'h4);
        // backup rail lost: the running tick count must freeze
        @(posedge clk);
        bak <= 1'b0;
        repeat (3) @(posedge clk);
        rd_reg(bbcc_pkg::A_TNOW);
        n = int'(rv);
        repeat (2600) @(posedge clk);
        rd_reg(bbcc_pkg::A_TNOW);
        chk(rv, n);
        finish_test();
    end
endmodule : bbcc_top_tb_top
